// ===== verilog/dtc_top.sv
/*
 * Dual 8-bit timer/counter with a Wishbone classic register slave,
 * sticky overflow flags, a mask register and one interrupt line.
 * Assumes a 32-bit Wishbone master on clk_i and a sleep level from the core.
 */
// Functional notes
// [R1] Timer mode without prescaler counts once every instruction cycle.
// [R2] Writing the count register holds off counting for two instruction cycles; counter mode here ignores the hold-off.
// [R3] Counter mode counts the external pin, or capsense oscillator when selected.
// [R4] Edge select one counts falling edges, zero counts rising edges.
// [R5] Bypass feeds the counter directly; otherwise the prescaler output clocks it.
// [R6] Prescale field 000..111 divides by 2..256; 1:1 needs bypass.
// [R7] Prescaler hidden from software; count writes clear it.
// [R8] Setting the run bit clears the prescaler.
// [R9] Rollover from maximum to zero sets the overflow flag regardless of enable.
// [R10] Only software clears the flag; interrupt needs flag and enable.
// [R11] Counter mode increments are synchronised on second and fourth phases.
// [R12] Counting only while run bit set; otherwise count holds.
// [R13] Sleep stops counting and keeps the count.
// [R14] Timer A overflow gates first 16-bit timer, B gates second.
// [R15] Overflow to gate logic is a one-cycle pulse at rollover.
`timescale 1ns/1ps
`default_nettype none
`include "dtc_params.svh"

module dtc_top
    import dtc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic sleep_i,
    input wire logic pin_a_i,
    input wire logic pin_b_i,
    input wire logic osc_a_i,
    input wire logic osc_b_i,
    output logic gate_a_o,
    output logic gate_b_o,
    output logic irq_o
);

    dtc_bus_state_t state_reg, state_next;
    logic [31:0] rdata_reg, rdata_next;
    dtc_byte_t ctrl_a_reg, ctrl_a_next;
    dtc_byte_t ctrl_b_reg, ctrl_b_next;
    logic [1:0] src_reg, src_next;
    logic [1:0] status_reg, status_next;
    logic [1:0] mask_reg, mask_next;
    logic q2, q4;
    logic wr, lane0;
    logic we_cnt_a, we_cnt_b, rise_a, rise_b;
    logic [7:0] count_a, count_b;
    logic ovf_a, ovf_b;

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr[7:2] == off[7:2]);
    endfunction : hit

    // Sleep freezes the instruction phases, so no count register advances
    dtc_phase_gen u_phase (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sleep_i(sleep_i), // R13
        .q2_o(q2),
        .q4_o(q4),
        .inst_o()
    );

    assign wr = cyc_i && stb_i && we_i && (state_reg == DTC_BUS_IDLE);
    assign lane0 = sel_i[0];
    assign we_cnt_a = wr && lane0 && hit(adr_i, `DTC_OFF_A_COUNT);
    assign we_cnt_b = wr && lane0 && hit(adr_i, `DTC_OFF_B_COUNT);
    assign rise_a = ctrl_a_next[`DTC_BIT_RUN] && !ctrl_a_reg[`DTC_BIT_RUN]; // R8
    assign rise_b = ctrl_b_next[`DTC_BIT_RUN] && !ctrl_b_reg[`DTC_BIT_RUN]; // R8

    dtc_unit #(.WIDTH(8)) u_unit_a (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .q2_i(q2),
        .q4_i(q4),
        .ctrl_i(ctrl_a_reg),
        .xcs_i(src_reg[`DTC_BIT_XCS_A]),
        .pin_i(pin_a_i),
        .osc_i(osc_a_i),
        .count_we_i(we_cnt_a),
        .run_rise_i(rise_a),
        .count_wdata_i(dat_i[7:0]),
        .count_o(count_a),
        .ovf_o(ovf_a)
    );

    dtc_unit #(.WIDTH(8)) u_unit_b (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .q2_i(q2),
        .q4_i(q4),
        .ctrl_i(ctrl_b_reg),
        .xcs_i(src_reg[`DTC_BIT_XCS_B]),
        .pin_i(pin_b_i),
        .osc_i(osc_b_i),
        .count_we_i(we_cnt_b),
        .run_rise_i(rise_b),
        .count_wdata_i(dat_i[7:0]),
        .count_o(count_b),
        .ovf_o(ovf_b)
    );

    always_comb begin
        state_next = DTC_BUS_IDLE;
        rdata_next = rdata_reg;
        ctrl_a_next = ctrl_a_reg;
        ctrl_b_next = ctrl_b_reg;
        src_next = src_reg;
        mask_next = mask_reg;
        status_next = status_reg;
        if (cyc_i && stb_i && state_reg == DTC_BUS_IDLE) begin
            state_next = DTC_BUS_ACK;
            if (wr && lane0) begin
                if (hit(adr_i, `DTC_OFF_A_CONTROL)) begin
                    ctrl_a_next = dat_i[7:0] & `DTC_CTRL_MASK;
                end
                if (hit(adr_i, `DTC_OFF_B_CONTROL)) begin
                    ctrl_b_next = dat_i[7:0] & `DTC_CTRL_MASK;
                end
                if (hit(adr_i, `DTC_OFF_SOURCE)) begin
                    src_next = dat_i[1:0];
                end
                if (hit(adr_i, `DTC_OFF_MASK)) begin
                    mask_next = dat_i[1:0];
                end
                if (hit(adr_i, `DTC_OFF_STATUS)) begin
                    status_next = status_reg & ~dat_i[1:0]; // R10
                end
            end
            rdata_next = 32'h0;
            if (!we_i) begin
                case ({2'b00, adr_i[7:2]})
                    `DTC_OFF_A_CONTROL >> 2: rdata_next[7:0] = ctrl_a_reg;
                    `DTC_OFF_B_CONTROL >> 2: rdata_next[7:0] = ctrl_b_reg;
                    `DTC_OFF_A_COUNT >> 2: rdata_next[7:0] = count_a;
                    `DTC_OFF_B_COUNT >> 2: rdata_next[7:0] = count_b;
                    `DTC_OFF_SOURCE >> 2: rdata_next[1:0] = src_reg;
                    `DTC_OFF_STATUS >> 2: rdata_next[1:0] = status_reg;
                    `DTC_OFF_MASK >> 2: rdata_next[1:0] = mask_reg;
                    default: rdata_next = 32'h0;
                endcase
            end
        end
        // Set wins over a software clear in the same cycle
        if (ovf_a) begin
            status_next[`DTC_BIT_OVF_A] = 1'b1; // R9
        end
        if (ovf_b) begin
            status_next[`DTC_BIT_OVF_B] = 1'b1; // R9
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= DTC_BUS_IDLE;
            rdata_reg <= 32'h0;
            ctrl_a_reg <= `DTC_RST_CONTROL;
            ctrl_b_reg <= `DTC_RST_CONTROL;
            src_reg <= `DTC_RST_SOURCE;
            status_reg <= `DTC_RST_STATUS;
            mask_reg <= `DTC_RST_MASK;
        end else begin
            state_reg <= state_next;
            rdata_reg <= rdata_next;
            ctrl_a_reg <= ctrl_a_next;
            ctrl_b_reg <= ctrl_b_next;
            src_reg <= src_next;
            status_reg <= status_next;
            mask_reg <= mask_next;
        end
    end

    assign ack_o = (state_reg == DTC_BUS_ACK);
    assign dat_o = rdata_reg;
    assign irq_o = |(status_reg & mask_reg); // R10
    assign gate_a_o = ovf_a; // R14 R15
    assign gate_b_o = ovf_b; // R14 R15

endmodule : dtc_top

`default_nettype wire

// ===== verilog/dtc_params.svh
/*
 * Register offsets, field positions, reset values and timing counts
 * for the dual 8-bit timer/counter block.
 * Assumes a 32-bit classic Wishbone bus with byte addressing.
 */
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// Register byte offsets
`define DTC_OFF_A_CONTROL 8'h00
`define DTC_OFF_B_CONTROL 8'h04
`define DTC_OFF_A_COUNT 8'h08
`define DTC_OFF_B_COUNT 8'h0c
`define DTC_OFF_SOURCE 8'h10
`define DTC_OFF_STATUS 8'h14
`define DTC_OFF_MASK 8'h18

// Control register fields
`define DTC_BIT_RUN 7
`define DTC_BIT_CS 5
`define DTC_BIT_SE 4
`define DTC_BIT_PSA 3
`define DTC_PS_MSB 2
`define DTC_PS_LSB 0
`define DTC_CTRL_MASK 8'hbf

// Source register: capsense clock select per unit
`define DTC_BIT_XCS_A 0
`define DTC_BIT_XCS_B 1

// Status and mask bits
`define DTC_BIT_OVF_A 0
`define DTC_BIT_OVF_B 1

// Reset values
`define DTC_RST_CONTROL 8'h00
`define DTC_RST_COUNT 8'h00
`define DTC_RST_SOURCE 2'h0
`define DTC_RST_STATUS 2'h0
`define DTC_RST_MASK 2'h0

// Internal phases per instruction cycle and write inhibit length
`define DTC_PHASES 4
`define DTC_WRITE_INHIBIT 2

`endif

// ===== verilog/dtc_pkg.sv
/*
 * Types for the dual 8-bit timer/counter block.
 * Assumes dtc_params.svh supplies the numeric constants.
 */
package dtc_pkg;

    typedef enum logic [1:0] {
        DTC_BUS_IDLE = 2'b00,
        DTC_BUS_ACK = 2'b01
    } dtc_bus_state_t;

    typedef logic [7:0] dtc_byte_t;

endpackage : dtc_pkg

// ===== verilog/dtc_phase_gen.sv
/*
 * Instruction-cycle phase generator: four internal phases per
 * instruction cycle, derived from the system clock.
 * Assumes clk_i is the oscillator clock and rst_i synchronous.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dtc_params.svh"

module dtc_phase_gen
    import dtc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sleep_i,
    output logic q2_o,
    output logic q4_o,
    output logic inst_o
);

    logic [1:0] phase_reg;
    logic [1:0] phase_next;

    always_comb begin
        phase_next = phase_reg;
        // Phases freeze in sleep
        if (!sleep_i) begin
            phase_next = phase_reg + 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_reg <= 2'h0;
        end else begin
            phase_reg <= phase_next;
        end
    end

    assign q2_o = !sleep_i && (phase_reg == 2'h1);
    assign q4_o = !sleep_i && (phase_reg == 2'h3);
    assign inst_o = q4_o;

endmodule : dtc_phase_gen

`default_nettype wire

// ===== verilog/dtc_unit.sv
/*
 * One 8-bit timer/counter with prescaler, edge select and sync.
 * Assumes phase strobes from dtc_phase_gen and writes from the bus.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dtc_params.svh"

module dtc_unit
    import dtc_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic q2_i,
    input wire logic q4_i,
    input wire logic [7:0] ctrl_i,
    input wire logic xcs_i,
    input wire logic pin_i,
    input wire logic osc_i,
    input wire logic count_we_i,
    input wire logic run_rise_i,
    input wire logic [WIDTH-1:0] count_wdata_i,
    output logic [WIDTH-1:0] count_o,
    output logic ovf_o
);

    logic [WIDTH-1:0] count_reg, count_next;
    logic [7:0] pre_reg, pre_next;
    logic [1:0] inh_reg, inh_next;
    logic src_reg, src_next;
    logic sync_reg, sync_next;
    logic ovf_reg, ovf_next;
    logic run, cs, se, psa;
    logic src, edge_hit, tick, pre_tap, pre_prev, pre_out;
    logic [2:0] ps;

    assign run = ctrl_i[`DTC_BIT_RUN];
    assign cs = ctrl_i[`DTC_BIT_CS];
    assign se = ctrl_i[`DTC_BIT_SE];
    assign psa = ctrl_i[`DTC_BIT_PSA];
    assign ps = ctrl_i[`DTC_PS_MSB:`DTC_PS_LSB];

    always_comb begin
        src = xcs_i ? osc_i : pin_i; // R3
        // Edge chosen by select bit: 1 falls, 0 rises
        edge_hit = se ? (src_reg && !src) : (!src_reg && src); // R4
        // Timer mode ticks every instruction cycle
        tick = cs ? edge_hit : q4_i; // R1 R3
        pre_tap = pre_reg[ps]; // R6
        pre_next = pre_reg;
        if (count_we_i || run_rise_i) begin
            pre_next = 8'h00; // R7 R8
        end else if (run && tick && !psa) begin
            pre_next = pre_reg + 8'h01;
        end
        pre_prev = pre_next[ps];
        // Prescaler output: falling of tap bit completes one divided period
        pre_out = pre_tap && !pre_prev && run && tick && !psa; // R6
    end

    always_comb begin
        src_next = src;
        sync_next = sync_reg;
        count_next = count_reg;
        inh_next = inh_reg;
        ovf_next = 1'b0;
        if (count_we_i) begin
            count_next = count_wdata_i;
            inh_next = 2'(`DTC_WRITE_INHIBIT); // R2
            sync_next = 1'b0;
        end else begin
            // Hold-off runs out in instruction cycles, so none is left stale
            if (q4_i && (inh_reg != 2'h0)) begin
                inh_next = inh_reg - 2'h1; // R2
            end
            if (run) begin // R12
                if (cs) begin
                    if ((q2_i || q4_i) && sync_reg) begin // R11
                        sync_next = 1'b0;
                        count_next = count_reg + 1'b1;
                        ovf_next = &count_reg; // R9
                    end
                end else if (q4_i && (inh_reg == 2'h0)) begin
                    if (psa ? 1'b1 : pre_out) begin // R5
                        count_next = count_reg + 1'b1; // R1
                        ovf_next = &count_reg; // R9
                    end
                end
            end
            // Counter-mode increments wait in sync latch, taken on Q2/Q4;
            // an edge in the consuming cycle is kept, not lost
            if (cs && (psa ? (run && tick) : pre_out)) begin
                sync_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= WIDTH'(`DTC_RST_COUNT);
            pre_reg <= 8'h00;
            inh_reg <= 2'h0;
            src_reg <= 1'b0;
            sync_reg <= 1'b0;
            ovf_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            pre_reg <= pre_next;
            inh_reg <= inh_next;
            src_reg <= src_next;
            sync_reg <= sync_next;
            ovf_reg <= ovf_next;
        end
    end

    assign count_o = count_reg;
    assign ovf_o = ovf_reg; // R15

endmodule : dtc_unit

`default_nettype wire

// ===== dv/dtc_chk.sv
/*
 * Port-level assertions for dtc_top: bus answers, gate pulses, interrupt.
 * Assumes it is bound to dtc_top and sees only that module's ports.
 */
`timescale 1ns/1ps
`default_nettype none
module dtc_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic sleep_i,
    input wire logic gate_a_o,
    input wire logic gate_b_o,
    input wire logic irq_o
);
    logic [2:0] evt_reg;
    logic [2:0] evt_next;
    logic [2:0] wr_reg;
    logic [2:0] wr_next;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Cycles since a bus write or an overflow pulse
    always_comb begin
        evt_next = (evt_reg == 3'h7) ? evt_reg : evt_reg + 3'h1;
        wr_next = (wr_reg == 3'h7) ? wr_reg : wr_reg + 3'h1;
        if (cyc_i && stb_i && we_i) begin
            evt_next = 3'h0;
            wr_next = 3'h0;
        end
        if (gate_a_o || gate_b_o) begin
            evt_next = 3'h0;
        end
    end
    always_ff @(posedge clk_i) begin
        evt_reg <= rst_i ? 3'h7 : evt_next;
        wr_reg <= rst_i ? 3'h7 : wr_next;
    end
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
    a_ack_latency: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
    a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
    a_read_upper: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0) else $error("upper");
    a_gate_a_pulse: assert property (gate_a_o |=> !gate_a_o [*3]) else $error("gate a");
    a_gate_b_pulse: assert property (gate_b_o |=> !gate_b_o [*3]) else $error("gate b");
    a_sleep_frozen: assert property (sleep_i [*4] |-> !gate_a_o && !gate_b_o)
        else $error("count in sleep");
    a_irq_rise: assert property ($rose(irq_o) |-> evt_reg < 3'h5) else $error("irq rose");
    a_irq_fall: assert property ($fell(irq_o) |-> wr_reg < 3'h5) else $error("irq fell");
endmodule : dtc_chk
bind dtc_top dtc_chk dtc_chk_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o), .sleep_i(sleep_i), .gate_a_o(gate_a_o),
    .gate_b_o(gate_b_o), .irq_o(irq_o));
`default_nettype wire

// ===== dv/dtc_src_model.sv
/*
 * Count source model: toggles one of pin A, pin B, osc A, osc B n times.
 * Assumes sel_i is held steady while busy_o is high.
 */
`timescale 1ns/1ps
`default_nettype none
module dtc_src_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic [1:0] sel_i,
    input wire logic [10:0] n_i,
    output logic [3:0] line_o,
    output logic busy_o
);
    logic [3:0] lvl_reg;
    logic [3:0] lvl_next;
    logic [10:0] left_reg;
    logic [10:0] left_next;
    logic [2:0] gap_reg;
    logic [2:0] gap_next;
    always_comb begin
        lvl_next = lvl_reg;
        left_next = left_reg;
        gap_next = (gap_reg == 3'h0) ? 3'h5 : gap_reg - 3'h1;
        if (left_reg == 11'h0) begin
            left_next = go_i ? n_i : 11'h0;
        end else if (gap_reg == 3'h0) begin
            // Six clocks per level so phase sampling sees each one
            lvl_next[sel_i] = ~lvl_reg[sel_i];
            left_next = left_reg - 11'h1;
        end
    end
    always_ff @(posedge clk_i) begin
        lvl_reg <= rst_i ? 4'h0 : lvl_next;
        left_reg <= rst_i ? 11'h0 : left_next;
        gap_reg <= rst_i ? 3'h0 : gap_next;
    end
    assign line_o = lvl_reg;
    assign busy_o = (left_reg != 11'h0);
endmodule : dtc_src_model
`default_nettype wire

// ===== dv/dual_8bit_timer_counter_bench.sv
/*
 * Self-checking bench for dtc_top with the count source model.
 * Assumes a 20 MHz clock and Wishbone classic single cycles.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dtc_params.svh"
module dual_8bit_timer_counter_bench;
    typedef struct packed {
        logic u;
        logic x;
        logic [7:0] ctrl;
        logic [10:0] n;
        logic [7:0] exp;
    } dtc_row_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic sleep_i = 1'b0;
    logic go = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [1:0] src_sel = 2'h0;
    logic [10:0] src_n = 11'h000;
    logic [31:0] dat_o;
    logic ack_o;
    logic gate_a_o;
    logic gate_b_o;
    logic irq_o;
    logic busy;
    logic [3:0] line;
    logic [7:0] q;
    dtc_row_t rows[12];
    int n_errors = 0;
    int total_checks = 0;
    always #25 clk_i = ~clk_i;
    dtc_top dtc_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .sleep_i(sleep_i), .pin_a_i(line[0]), .pin_b_i(line[1]),
        .osc_a_i(line[2]), .osc_b_i(line[3]), .gate_a_o(gate_a_o),
        .gate_b_o(gate_b_o), .irq_o(irq_o));
    dtc_src_model dtc_src_model_i (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
        .sel_i(src_sel), .n_i(src_n), .line_o(line), .busy_o(busy));
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'h1;
        dat_i <= {24'h0, d};
        for (k = 0; k < 20 && ack_o !== 1'b1; k++) begin
            @(negedge clk_i);
        end
        if (k == 20) begin
            chk(32'h0, 32'h1);
            complete_run();
        end
        @(posedge clk_i);
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic toggle(input logic [1:0] s, input logic [10:0] n);
        int k;
        src_sel <= s;
        src_n <= n;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        @(negedge clk_i);
        for (k = 0; k < 8000 && busy !== 1'b0; k++) begin
            @(negedge clk_i);
        end
        chk(k < 8000, 32'h1);
        if (k == 8000) begin
            complete_run();
        end
        repeat (8) @(posedge clk_i);
    endtask : toggle
    task automatic wait_gate(input logic u, input int lo, input int hi);
        int k;
        @(negedge clk_i);
        for (k = 0; k < 1100 && (u ? gate_b_o : gate_a_o) !== 1'b1; k++) begin
            @(negedge clk_i);
        end
        chk(k >= lo && k <= hi, 32'h1);
        if (k == 1100) begin
            complete_run();
        end
        @(posedge clk_i);
    endtask : wait_gate
    task automatic irq_is(input logic e);
        @(negedge clk_i);
        chk(irq_o, e);
        @(posedge clk_i);
    endtask : irq_is
    task automatic setup(input logic u, input logic x, input logic [7:0] c);
        wb(1'b1, 8'(u * 4), 8'h00);
        wb(1'b1, `DTC_OFF_SOURCE, {6'h0, x & u, x & ~u});
        wb(1'b1, 8'(8 + u * 4), 8'h00);
        wb(1'b1, 8'(u * 4), c);
        repeat (12) @(posedge clk_i);
    endtask : setup
    initial begin
        rows[0] = '{1'b0, 1'b0, 8'ha8, 11'h00a, 8'h05};
        rows[1] = '{1'b1, 1'b0, 8'hb8, 11'h00a, 8'h05};
        rows[2] = '{1'b0, 1'b1, 8'ha8, 11'h004, 8'h02};
        rows[3] = '{1'b0, 1'b0, 8'h28, 11'h006, 8'h00};
        for (int k = 0; k < 8; k++) begin
            rows[4 + k] = '{k[0], k[1], 8'ha0 | {3'h0, k[2], 4'h0} | 8'(k), 11'((8 << k) - 2), 8'h01};
        end
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 32; a += 4) begin
            wb(1'b0, 8'(a), 8'h00);
            chk(q, 32'h0);
        end
        wb(1'b1, `DTC_OFF_A_CONTROL, 8'hff);
        wb(1'b0, `DTC_OFF_A_CONTROL, 8'h00);
        chk(q, 32'hbf);
        wb(1'b1, 8'h1c, 8'h5a);
        wb(1'b0, 8'h1c, 8'h00);
        chk(q, 32'h0);
        $display("test registers done");
        foreach (rows[i]) begin
            setup(rows[i].u, rows[i].x, rows[i].ctrl);
            toggle({rows[i].x, rows[i].u}, rows[i].n);
            wb(1'b0, 8'(8 + rows[i].u * 4), 8'h00);
            chk(q, rows[i].exp);
        end
        $display("test count rows done");
        setup(1'b0, 1'b0, 8'hb8);
        toggle(2'h0, 11'h001);
        wb(1'b0, `DTC_OFF_A_COUNT, 8'h00);
        chk(q, 32'h0);
        toggle(2'h0, 11'h001);
        wb(1'b0, `DTC_OFF_A_COUNT, 8'h00);
        chk(q, 32'h1);
        setup(1'b0, 1'b0, 8'ha0);
        toggle(2'h0, 11'h002);
        wb(1'b1, `DTC_OFF_A_COUNT, 8'h00);
        repeat (12) @(posedge clk_i);
        toggle(2'h0, 11'h002);
        wb(1'b0, `DTC_OFF_A_COUNT, 8'h00);
        chk(q, 32'h0);
        $display("test edges done");
        for (int u = 0; u < 2; u++) begin
            setup(u[0], 1'b0, 8'h88);
            wb(1'b1, 8'(8 + u * 4), 8'hff);
            wait_gate(u[0], 6, 12);
            wait_gate(u[0], 1023, 1023);
            wb(1'b0, `DTC_OFF_STATUS, 8'h00);
            chk(q, 32'h1 << u);
            irq_is(1'b0);
            wb(1'b1, `DTC_OFF_MASK, 8'(1 << u));
            irq_is(1'b1);
            wb(1'b1, `DTC_OFF_STATUS, 8'(1 << u));
            irq_is(1'b0);
            wb(1'b1, `DTC_OFF_MASK, 8'h00);
            wb(1'b1, 8'(u * 4), 8'h00);
        end
        $display("test overflow done");
        setup(1'b0, 1'b0, 8'h88);
        wb(1'b1, `DTC_OFF_A_COUNT, 8'h80);
        sleep_i <= 1'b1;
        repeat (300) @(posedge clk_i);
        wb(1'b0, `DTC_OFF_A_COUNT, 8'h00);
        chk(q, 32'h80);
        sleep_i <= 1'b0;
        $display("test sleep done");
        // Mid-run reset with timer A running and registers loaded
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 28; a += 4) begin
            wb(1'b0, 8'(a), 8'h00);
            chk(q, 32'h0);
        end
        irq_is(1'b0);
        $display("test reset done");
        complete_run();
    end
endmodule : dual_8bit_timer_counter_bench
`default_nettype wire
